/* File: core/hwtec_trigger_exposure.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - acquisition starts on rising or falling trigger edge, chosen by setting
// - after reset the trigger comes from input line 1
// - trigger source selectable between input line 1 and line 2
// - one image acquired per trigger period
// - two exposure modes: timed and pulse width
// - timed mode exposes from active edge for the programmed time
// - width mode, rising edge: expose from rise until next fall
// - width mode, falling edge: expose from fall until next rise
// - width mode with overlap enabled still uses exposure time to drive trigger ready
// - width mode ending during previous readout extends until readout done
// - trigger obeyed only with acquisition-start selected and enabled
// - single-frame start command arms for exactly one trigger
// - single-frame ignores later triggers until the next start command
// - trigger ready output is high when a trigger can be taken and readout is idle, or with overlap fits in the exposure time
// - when exposure ends the image is read out and sent
// - continuous start command arms for a series of triggers
// - stop command ends response to hardware triggers
module hwtec_trigger_exposure #(
  parameter int EXP_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] external_trigger_in,
  output logic trigger_ready_out,
  output logic exposure_active,
  output logic readout_active,
  output logic frame_done
);

  // ==========================================================
  // parameter checks
  generate
    if (EXP_W < 2 || EXP_W > 32)
    begin : g_bad_w
      $error("EXP_W must lie in 2..32");
    end
    if (hwtec_pkg::SYNC_AGREE_CYC > hwtec_pkg::TRIG_MIN_CYC)
    begin : g_bad_sync
      $error("sync filter longer than minimum trigger pulse");
    end
    if (EXP_W < $clog2(hwtec_pkg::READOUT_RESET + 1))
    begin : g_bad_rst
      $error("EXP_W too narrow for the reset counts");
    end
  endgenerate

  // one-cycle remainder marks the last count of a run
  localparam logic [EXP_W-1:0] CNT_ONE = EXP_W'(1);

  // ==========================================================
  // bus slave
  logic wr_pend;
  logic [hwtec_pkg::ADDR_W-1:0] wr_addr;
  hwtec_pkg::hwtec_ctrl_t ctrl;
  logic [EXP_W-1:0] exp_time;
  logic [EXP_W-1:0] ro_len;
  logic [31:0] frames;
  hwtec_pkg::hwtec_status_t status;
  logic [EXP_W-1:0] rd_cnt;

  wire addr_phase = hsel && hready && (htrans == hwtec_pkg::HTRANS_NONSEQ);
  wire [hwtec_pkg::ADDR_W-1:0] a_addr = haddr[hwtec_pkg::ADDR_W-1:0];
  wire wr_ctrl = wr_pend && (wr_addr == hwtec_pkg::ADDR_CTRL);
  wire wr_exp = wr_pend && (wr_addr == hwtec_pkg::ADDR_EXPOSURE);
  wire wr_cmd = wr_pend && (wr_addr == hwtec_pkg::ADDR_CMD);
  wire wr_ro = wr_pend && (wr_addr == hwtec_pkg::ADDR_READOUT);
  wire cmd_start = wr_cmd && hwdata[hwtec_pkg::CMD_START];
  wire cmd_stop = wr_cmd && hwdata[hwtec_pkg::CMD_STOP];

  function automatic logic [31:0] widen(input logic [EXP_W-1:0] v);
    logic [31:0] w;
    w = hwtec_pkg::WORD_ZERO;
    w[EXP_W-1:0] = v;
    return w;
  endfunction : widen

  wire [31:0] rd_mux =
    (a_addr == hwtec_pkg::ADDR_CTRL) ?
      {{(32-hwtec_pkg::CTRL_W){1'b0}}, ctrl} :
    (a_addr == hwtec_pkg::ADDR_EXPOSURE) ? widen(exp_time) :
    (a_addr == hwtec_pkg::ADDR_STATUS) ?
      {{(32-$bits(status)){1'b0}}, status} :
    (a_addr == hwtec_pkg::ADDR_READOUT) ? widen(ro_len) :
    (a_addr == hwtec_pkg::ADDR_FRAMES) ? frames :
    hwtec_pkg::WORD_ZERO;

  // zero wait states: hreadyout never drops, hresp stays okay
  // read data stands only in the data phase, zero otherwise
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= hwtec_pkg::WORD_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= a_addr;
      hrdata <= (addr_phase && !hwrite) ? rd_mux : hwtec_pkg::WORD_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= hwtec_pkg::CTRL_RESET;
      exp_time <= hwtec_pkg::EXPOSURE_RESET[EXP_W-1:0];
      ro_len <= hwtec_pkg::READOUT_RESET[EXP_W-1:0];
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata[hwtec_pkg::CTRL_W-1:0];
      if (wr_exp)
        exp_time <= hwdata[EXP_W-1:0];
      if (wr_ro)
        ro_len <= hwdata[EXP_W-1:0];
    end
  end

  // ==========================================================
  // trigger input synchronisers
  // a level moves only after flops two and three agree,
  // so a lone glitch on the pin never reaches edge logic
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] line_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          line_lvl[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= external_trigger_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi])
            line_lvl[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // edge detection on the chosen line
  // sel_prev follows the chosen line, so changing the source
  // can itself look like an edge while idle
  logic sel_prev;
  wire sel_lvl = ctrl.source_line2 ? line_lvl[1] : line_lvl[0];
  wire rise = sel_lvl && !sel_prev;
  wire fall = !sel_lvl && sel_prev;
  wire act_edge = ctrl.falling_edge ? fall : rise;
  wire end_edge = ctrl.falling_edge ? rise : fall;
  wire trig_on = ctrl.trig_on && ctrl.sel_acq_start;

  // ==========================================================
  // exposure sequencer
  // extend holds the exposure open until the previous readout
  // has drained; timed mode takes the same path
  hwtec_pkg::hwtec_state_t state;
  hwtec_pkg::hwtec_state_t next_state;
  logic armed;
  logic [EXP_W-1:0] exp_cnt;

  wire ro_busy = (rd_cnt != '0);
  wire accept = act_edge && trig_on && armed &&
    (state == hwtec_pkg::ST_IDLE);
  wire timed_done = !ctrl.width_mode && (exp_cnt <= CNT_ONE);
  wire width_done = ctrl.width_mode && end_edge;
  wire exp_end = (state == hwtec_pkg::ST_EXPOSE) &&
    (timed_done || width_done);
  wire ro_start = ((exp_end || state == hwtec_pkg::ST_EXTEND) &&
    !ro_busy);

  always_comb
  begin
    next_state = state;
    case (state)
      hwtec_pkg::ST_IDLE:
        if (accept)
          next_state = hwtec_pkg::ST_EXPOSE;
      hwtec_pkg::ST_EXPOSE:
        if (exp_end)
          next_state = ro_busy ? hwtec_pkg::ST_EXTEND
                               : hwtec_pkg::ST_IDLE;
      hwtec_pkg::ST_EXTEND:
        if (!ro_busy)
          next_state = hwtec_pkg::ST_IDLE;
      default:
        next_state = hwtec_pkg::ST_IDLE;
    endcase
  end

  // stop beats start; a start in the accept cycle re-arms
  wire next_armed = cmd_stop ? 1'b0 :
    cmd_start ? 1'b1 :
    (accept && !ctrl.continuous) ? 1'b0 :
    armed;

  // ready: idle, armed, enabled, and readout clears within the
  // programmed exposure time when overlapped
  wire ro_fits = ctrl.overlap_en ? (rd_cnt <= exp_time)
                                 : !ro_busy;
  wire next_ready = (next_state == hwtec_pkg::ST_IDLE) && next_armed &&
    trig_on && ro_fits;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= hwtec_pkg::ST_IDLE;
      armed <= 1'b0;
      sel_prev <= 1'b0;
      exp_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      armed <= next_armed;
      sel_prev <= sel_lvl;
      if (accept)
        exp_cnt <= exp_time;
      else if (state == hwtec_pkg::ST_EXPOSE && exp_cnt != '0)
        exp_cnt <= exp_cnt - 1'b1;
    end
  end

  // ==========================================================
  // readout and outputs
  // readout is a plain countdown; a zero length still takes
  // one cycle so frame_done always follows a readout
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_cnt <= '0;
      frames <= hwtec_pkg::WORD_ZERO;
      trigger_ready_out <= 1'b0;
      exposure_active <= 1'b0;
      readout_active <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      if (ro_start)
        rd_cnt <= (ro_len == '0) ? CNT_ONE : ro_len;
      else if (ro_busy)
        rd_cnt <= rd_cnt - 1'b1;
      if (ro_start)
        frames <= frames + hwtec_pkg::WORD_ONE;
      trigger_ready_out <= next_ready;
      exposure_active <= (next_state != hwtec_pkg::ST_IDLE);
      readout_active <= ro_start || (rd_cnt > CNT_ONE);
      frame_done <= (rd_cnt == CNT_ONE) && !ro_start;
    end
  end

  assign status = '{
    state: state,
    readout_busy: ro_busy,
    exposing: exposure_active,
    ready: trigger_ready_out,
    armed: armed
  };

  // bus attributes that a word-only slave does not decode
  wire unused_ok = &{1'b0, hsize, haddr[31:hwtec_pkg::ADDR_W]};

endmodule : hwtec_trigger_exposure

/* File: pkg/hwtec_pkg.sv */
package hwtec_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_READOUT = 8'h10;
  localparam logic [7:0] ADDR_FRAMES = 8'h14;
  localparam int ADDR_W = 8;

  // ==========================================================
  // field positions
  localparam int CTRL_W = 7;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [31:0] EXPOSURE_RESET = 32'h0000_03E8;
  localparam logic [31:0] READOUT_RESET = 32'h0000_07D0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONE = 32'h0000_0001;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TRIG_MIN_NS = 100;
  localparam int TRIG_MIN_CYC =
    (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_AGREE_CYC = 2;

  // ==========================================================
  // types
  typedef struct packed {
    logic overlap_en;
    logic continuous;
    logic width_mode;
    logic falling_edge;
    logic source_line2;
    logic sel_acq_start;
    logic trig_on;
  } hwtec_ctrl_t;

  localparam hwtec_ctrl_t CTRL_RESET = '0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXPOSE = 2'b01,
    ST_EXTEND = 2'b11
  } hwtec_state_t;

  typedef struct packed {
    logic [1:0] state;
    logic readout_busy;
    logic exposing;
    logic ready;
    logic armed;
  } hwtec_status_t;

endpackage : hwtec_pkg

/* File: tb/hwtec_asserts.sv */
`timescale 1ns/1ps
module hwtec_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic trigger_ready_out,
  input wire logic exposure_active,
  input wire logic readout_active,
  input wire logic frame_done
);
  logic rd_ph;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rd_ph <= 1'b0;
    else
      rd_ph <= hsel && hready && htrans == 2'h2 && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // assertions
  bus_okay_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not okay");
  rdata_idle_a: assert property (!rd_ph |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  reset_quiet_a: assert property (
    !$past(hresetn) |-> !exposure_active && !readout_active
    && !trigger_ready_out) else $error("outputs busy after reset");
  busy_no_ready_a: assert property (
    exposure_active && $past(exposure_active) |-> !trigger_ready_out)
    else $error("ready while exposing");
  done_pulse_a: assert property (frame_done |=> !frame_done)
    else $error("frame done too long");
  done_after_rdo_a: assert property (
    frame_done |-> $past(readout_active)) else $error("done w/o readout");
  rdo_end_done_a: assert property (
    $fell(readout_active) |-> frame_done) else $error("readout end no done");
  rdo_after_exp_a: assert property ($rose(readout_active) |->
    $past(exposure_active) || $past(exposure_active, 2))
    else $error("readout without exposure");
  exp_to_rdo_a: assert property (
    $fell(exposure_active) |-> ##[0:1] readout_active)
    else $error("exposure end without readout");
  cover property (frame_done);
  cover property ($rose(exposure_active) && readout_active);
  cover property ($fell(trigger_ready_out));
endmodule : hwtec_asserts

/* File: tb/hwtec_trig_src.sv */
`timescale 1ns/1ps
module hwtec_trig_src (
  input wire logic hclk,
  input wire logic trigger_ready_out,
  output logic [1:0] external_trigger_in
);
  initial external_trigger_in = 2'b00;
  // both lines rest at the inactive level
  task automatic idle(input logic fa);
    @(posedge hclk);
    external_trigger_in <= {2{fa}};
    repeat (6) @(posedge hclk);
  endtask : idle
  task automatic fire(input int ln, input logic fa, input int hi,
                      input logic ob);
    int n = 0;
    while (ob && trigger_ready_out !== 1'b1 && n < 5000)
    begin
      @(posedge hclk);
      n++;
    end
    @(posedge hclk);
    external_trigger_in[ln] <= !fa;
    repeat (hi) @(posedge hclk);
    external_trigger_in[ln] <= fa;
  endtask : fire
endmodule : hwtec_trig_src

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  wire logic hreadyout, hresp, trigger_ready_out;
  wire logic exposure_active, readout_active, frame_done;
  wire logic [31:0] hrdata;
  wire logic [1:0] external_trigger_in;
  int err_count = 0, n_compared = 0, el, rl, nf = 0;
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv[5] = '{0, hwtec_pkg::EXPOSURE_RESET,
    hwtec_pkg::READOUT_RESET, 0, 0};
  logic [31:0] nc[3] = '{32'h1, 32'h2, 32'h7};
  always #20 hclk = ~hclk;
  hwtec_trigger_exposure u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .external_trigger_in, .trigger_ready_out, .exposure_active,
    .readout_active, .frame_done);
  hwtec_trig_src u_src (.hclk, .trigger_ready_out, .external_trigger_in);
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= hwtec_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic trig(input int ln, input logic fa, input int hi,
                      input logic ob);
    el = 0;
    rl = 0;
    fork
      u_src.fire(ln, fa, hi, ob);
      begin
        repeat (60) if (exposure_active !== 1'b1) @(posedge hclk);
        while (exposure_active === 1'b1 && el < 300)
        begin
          el++;
          @(posedge hclk);
        end
        if (el > 0 && readout_active !== 1'b1) @(posedge hclk);
        while (readout_active === 1'b1 && rl < 300)
        begin
          rl++;
          @(posedge hclk);
        end
        if (el > 0) `CHK(frame_done, 1'b1)
      end
    join
  endtask : trig
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #1ms;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // ==========================================================
    // reset values and unmapped place
    foreach (ra[i])
    begin
      ahb(0, ra[i], 0);
      `CHK(r, rv[i])
    end
    ahb(1, 8'h18, 32'hFFFF_FFFF);
    ahb(0, 8'h18, 0);
    `CHK(r, hwtec_pkg::WORD_ZERO)
    ahb(1, hwtec_pkg::ADDR_EXPOSURE, 32'h5);
    ahb(1, hwtec_pkg::ADDR_READOUT, 32'h4);
    // ==========================================================
    // single frame, timed, line 1 default
    ahb(1, hwtec_pkg::ADDR_CTRL, 32'h3);
    ahb(1, hwtec_pkg::ADDR_CMD, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(trigger_ready_out, 1'b1)
    trig(0, 0, 3, 1);
    `CHK(el, 5)
    `CHK(rl, 4)
    trig(0, 0, 3, 0);
    `CHK(el, 0)
    foreach (nc[i])
    begin
      ahb(1, hwtec_pkg::ADDR_CTRL, nc[i]);
      ahb(1, hwtec_pkg::ADDR_CMD, 32'h1);
      trig(0, 0, 3, 0);
      `CHK(el, 0)
    end
    trig(1, 0, 3, 1);
    `CHK(el, 5)
    // ==========================================================
    // width mode, both edges
    for (int i = 0; i < 2; i++)
    begin
      u_src.idle(i[0]);
      ahb(1, hwtec_pkg::ADDR_CTRL, i ? 32'h1B : 32'h13);
      ahb(1, hwtec_pkg::ADDR_CMD, 32'h1);
      trig(0, i[0], 7 + i, 1);
      `CHK(el, 7 + i)
    end
    u_src.idle(0);
    // ==========================================================
    // continuous, then stop
    ahb(1, hwtec_pkg::ADDR_CTRL, 32'h23);
    ahb(1, hwtec_pkg::ADDR_CMD, 32'h1);
    repeat (3)
    begin
      trig(0, 0, 3, 1);
      `CHK(el, 5)
    end
    ahb(1, hwtec_pkg::ADDR_CMD, 32'h2);
    trig(0, 0, 3, 0);
    `CHK(el, 0)
    // ==========================================================
    // overlapped width exposure stretched by readout
    ahb(1, hwtec_pkg::ADDR_EXPOSURE, 32'h10);
    ahb(1, hwtec_pkg::ADDR_READOUT, 32'h1E);
    ahb(1, hwtec_pkg::ADDR_CTRL, 32'h73);
    ahb(1, hwtec_pkg::ADDR_CMD, 32'h1);
    u_src.fire(0, 0, 4, 1);
    repeat (20) @(posedge hclk);
    for (int n = 0; n < 60 && trigger_ready_out !== 1'b1; n++)
      @(posedge hclk);
    `CHK(readout_active, 1'b1)
    trig(0, 0, 3, 1);
    `CHK(el > 8, 1'b1)
    nf = 9;
    ahb(0, hwtec_pkg::ADDR_FRAMES, 0);
    `CHK(r, 32'(nf))
    report_and_stop();
  end
endmodule : tb_top
bind hwtec_trigger_exposure hwtec_asserts u_chk (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .trigger_ready_out, .exposure_active, .readout_active, .frame_done);
